// ### common/vdi_pkg.sv
// Constants and types shared by both ends of the decoder control port.
// Assumes a 100 MHz system clock at both ends.
package vdi_pkg;
    localparam logic [7:0] MAIN_ADDR_BASE  = 8'h40;
    localparam int         STRAP_BIT       = 1;
    localparam logic [7:0] SUBMAP_SEL_OFF  = 8'h0e;
    localparam int         SUBMAP_LSB      = 5;
    localparam logic [7:0] SUBMAP_RESET    = 8'h00;
    localparam logic [7:0] SECOND_ADDR_OFF = 8'hfe;
    localparam logic [7:0] SECOND_RESET    = 8'h00;
    localparam logic [7:0] DEF_TOP_SUB     = 8'hfe;
    // Effective map numbers; the sub-map select codes equal the first three
    localparam logic [1:0] MAP_USER        = 2'h0;
    localparam logic [1:0] MAP_INTR        = 2'h1;
    localparam logic [1:0] MAP_USER2       = 2'h2;
    localparam logic [1:0] MAP_SECOND      = 2'h3;
    // Controller register offsets and fields
    localparam logic [3:0] H_CTRL_OFF      = 4'h0;
    localparam logic [3:0] H_TARGET_OFF    = 4'h1;
    localparam logic [3:0] H_SUB_OFF       = 4'h2;
    localparam logic [3:0] H_STATUS_OFF    = 4'h3;
    localparam logic [3:0] H_DATA_OFF      = 4'h4;
    localparam int         CTRL_GO         = 0;
    localparam int         CTRL_READ       = 1;
    localparam int         CTRL_CNT_LSB    = 2;
    localparam int         STAT_BUSY       = 0;
    localparam int         STAT_NACK       = 1;
    localparam int         DATA_SLOTS      = 4;
    // Timing
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         SCL_PERIOD_NS   = 10000;
    localparam int         SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        D_IDLE, D_ADDR, D_A_ACK, D_SUB, D_S_ACK, D_WDATA, D_W_ACK,
        D_RDATA, D_R_ACK, D_R_LOAD
    } vdi_dev_state_t;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} vdi_host_state_t;

    typedef enum logic [2:0] {
        B_ADDRW, B_SUB, B_WDATA, B_ADDRR, B_RDATA
    } vdi_role_t;
endpackage : vdi_pkg

// ### common/vdi_link_if.sv
// Two-wire link between the controller and the decoder port.
// Both lines are open drain with a pull-up; each driver pulls low only.
`timescale 1ns/100ps
interface vdi_link_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Wired-and of the open-drain drivers
    assign scl = scl_host_oe ? scl_host_o : 1'b1;
    assign sda = (sda_host_oe ? sda_host_o : 1'b1)
               & (sda_dev_oe ? sda_dev_o : 1'b1);

    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host   (input sda, output scl_host_o, output scl_host_oe,
                    output sda_host_o, output sda_host_oe);
endinterface : vdi_link_if

// ### design/vdi_device.sv
// Decoder-side two-wire slave port with the main map, its sub maps and
// the second map. Assumes the link lines arrive unsynchronised.
`timescale 1ns/100ps
module vdi_device #(
    parameter logic [7:0] TOP_SUB = vdi_pkg::DEF_TOP_SUB
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    vdi_link_if.device      link,
    input  wire logic       address_select_strap,
    output logic [1:0]      sub_map_select,
    output logic [7:0]      second_map_bus_address,
    output logic            busy,
    output logic            wr_pulse,
    output logic [1:0]      wr_map,
    output logic [7:0]      wr_sub,
    output logic [7:0]      wr_data
);
    import vdi_pkg::*;

    typedef struct packed {
        logic           scl_m;
        logic           scl_s;
        logic           scl_p;
        logic           sda_m;
        logic           sda_s;
        logic           sda_p;
        logic           strap_m;
        logic           strap_s;
        vdi_dev_state_t st;
        logic [3:0]     cnt;
        logic [7:0]     sh;
        logic [7:0]     ptr;
        logic [1:0]     map;
        logic           over;
        logic           oe;
        logic [7:0]     smsel;
        logic [7:0]     sec;
        logic           wr;
        logic [1:0]     wmap;
        logic [7:0]     wsub;
        logic [7:0]     wdata;
    } vdi_dev_regs_t;

    vdi_dev_regs_t r;
    vdi_dev_regs_t next_r;
    logic [7:0]    mem [0:1023];
    logic [7:0]    main_addr;
    logic [7:0]    rbyte;
    logic          rise;
    logic          fall;
    logic          start;
    logic          stop;
    logic          main_hit;
    logic          sec_hit;

    assign rise  = r.scl_s & ~r.scl_p;
    assign fall  = ~r.scl_s & r.scl_p;
    assign start = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign stop  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;

    always_comb begin
        main_addr = MAIN_ADDR_BASE;
        main_addr[STRAP_BIT] = r.strap_s;
        main_hit = r.sh[7:1] == main_addr[7:1];
        // Zero address keeps the second map shut until programmed
        sec_hit = (r.sec[7:1] != 7'h00) && (r.sh[7:1] == r.sec[7:1]);
        if (r.map != MAP_SECOND && r.ptr == SUBMAP_SEL_OFF) begin
            rbyte = r.smsel;
        end else if (r.map == MAP_USER && r.ptr == SECOND_ADDR_OFF) begin
            rbyte = {r.sec[7:1], 1'b0};
        end else begin
            rbyte = mem[{r.map, r.ptr}];
        end
    end

    always_comb begin
        next_r = r;
        next_r.scl_m = link.scl;
        next_r.scl_s = r.scl_m;
        next_r.scl_p = r.scl_s;
        next_r.sda_m = link.sda;
        next_r.sda_s = r.sda_m;
        next_r.sda_p = r.sda_s;
        next_r.strap_m = address_select_strap;
        next_r.strap_s = r.strap_m;
        next_r.wr = 1'b0;
        if (start) begin
            next_r.st = D_ADDR;
            next_r.cnt = 4'h0;
            next_r.oe = 1'b0;
        end else if (stop) begin
            next_r.st = D_IDLE;
            next_r.oe = 1'b0;
        end else begin
            case (r.st)
                D_ADDR, D_SUB, D_WDATA: begin
                    if (rise) begin
                        next_r.sh = {r.sh[6:0], r.sda_s};
                        next_r.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == 4'h8) begin
                        next_r.cnt = 4'h0;
                        next_r.st = D_IDLE;
                        if (r.st == D_ADDR) begin
                            if (main_hit || sec_hit) begin
                                next_r.oe = 1'b1;
                                next_r.st = D_A_ACK;
                                if (main_hit) begin
                                    // Reserved code 11 falls back to user
                                    next_r.map = (r.smsel[6:5] == 2'b11) ?
                                        MAP_USER : r.smsel[6:5];
                                end else begin
                                    next_r.map = MAP_SECOND;
                                end
                            end
                        end else if (r.st == D_SUB) begin
                            if (r.sh <= TOP_SUB) begin
                                next_r.ptr = r.sh;
                                next_r.over = 1'b0;
                                next_r.oe = 1'b1;
                                next_r.st = D_S_ACK;
                            end
                        end else if (!r.over) begin
                            next_r.wr = 1'b1;
                            next_r.wmap = r.map;
                            next_r.wsub = r.ptr;
                            next_r.wdata = r.sh;
                            if (r.map != MAP_SECOND && r.ptr == SUBMAP_SEL_OFF) begin
                                next_r.smsel = r.sh;
                            end
                            if (r.map == MAP_USER && r.ptr == SECOND_ADDR_OFF) begin
                                next_r.sec = r.sh;
                            end
                            next_r.over = r.ptr == TOP_SUB;
                            if (r.ptr != TOP_SUB) begin
                                next_r.ptr = r.ptr + 8'h01;
                            end
                            next_r.oe = 1'b1;
                            next_r.st = D_W_ACK;
                        end
                    end
                end
                D_A_ACK, D_S_ACK, D_W_ACK: begin
                    if (fall) begin
                        next_r.oe = 1'b0;
                        next_r.st = D_WDATA;
                        if (r.st == D_A_ACK && r.sh[0]) begin
                            next_r.sh = rbyte;
                            next_r.oe = ~rbyte[7];
                            next_r.st = D_RDATA;
                        end else if (r.st == D_A_ACK) begin
                            next_r.st = D_SUB;
                        end
                    end
                end
                D_RDATA: begin
                    if (rise) begin
                        next_r.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == 4'h8) begin
                        next_r.oe = 1'b0;
                        next_r.st = D_R_ACK;
                    end else if (fall) begin
                        next_r.sh = {r.sh[6:0], 1'b0};
                        next_r.oe = ~r.sh[6];
                    end
                end
                D_R_ACK: begin
                    if (rise && r.sda_s) begin
                        next_r.st = D_IDLE;
                    end else if (rise) begin
                        next_r.st = D_R_LOAD;
                        if (r.ptr != TOP_SUB) begin
                            next_r.ptr = r.ptr + 8'h01;
                        end
                    end
                end
                D_R_LOAD: begin
                    if (fall) begin
                        next_r.cnt = 4'h0;
                        next_r.sh = rbyte;
                        next_r.oe = ~rbyte[7];
                        next_r.st = D_RDATA;
                    end
                end
                default: begin
                    next_r.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Storage outside the state record; written a cycle after the ack starts
    always_ff @(posedge clk) begin
        if (r.wr) begin
            mem[{r.wmap, r.wsub}] <= r.wdata;
        end
    end

    assign link.sda_dev_o          = 1'b0;
    assign link.sda_dev_oe         = r.oe;
    assign sub_map_select          = r.smsel[6:5];
    assign second_map_bus_address  = r.sec;
    assign busy                    = r.st != D_IDLE;
    assign wr_pulse                = r.wr;
    assign wr_map                  = r.wmap;
    assign wr_sub                  = r.wsub;
    assign wr_data                 = r.wdata;
endmodule : vdi_device

// ### design/vdi_host.sv
// Controller end: drives the link clock by a divider and runs one
// addressed transfer per command. Assumes software on the plain port.
`timescale 1ns/100ps
module vdi_host #(
    parameter int QUARTER   = vdi_pkg::SCL_QUARTER_CYC,
    parameter int MAX_BYTES = vdi_pkg::DATA_SLOTS
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    vdi_link_if.host        link,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata
);
    import vdi_pkg::*;

    typedef struct packed {
        logic                        sda_m;
        logic                        sda_s;
        vdi_host_state_t             st;
        logic [15:0]                 div;
        logic [1:0]                  q;
        logic [3:0]                  bitn;
        logic [7:0]                  tx;
        logic [7:0]                  rx;
        vdi_role_t                   role;
        logic [2:0]                  idx;
        logic [2:0]                  cnt;
        logic                        rw;
        logic [6:0]                  target;
        logic [7:0]                  sub;
        logic                        nack;
        logic                        scl_oe;
        logic                        sda_oe;
        logic [MAX_BYTES-1:0][7:0]   data;
        logic [7:0]                  rdata;
    } vdi_host_regs_t;

    vdi_host_regs_t r;
    vdi_host_regs_t next_r;
    logic           tick;
    logic           last;
    logic [7:0]     load;
    logic [7:0]     cur;

    assign tick = r.div == 16'(QUARTER - 1);
    assign last = r.idx == r.cnt;
    // First bit takes the byte of the role just entered, not the old one
    assign cur  = (r.bitn == 4'h0) ? load : r.tx;

    always_comb begin
        case (r.role)
            B_ADDRW: load = {r.target, 1'b0};
            B_ADDRR: load = {r.target, 1'b1};
            B_SUB:   load = r.sub;
            default: load = r.data[r.idx];
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.sda_m = link.sda;
        next_r.sda_s = r.sda_m;
        next_r.div = (r.st == H_IDLE || tick) ? 16'h0000 : r.div + 16'h0001;
        if (wr) begin
            if (addr == H_CTRL_OFF && wdata[CTRL_GO] && r.st == H_IDLE) begin
                next_r.rw = wdata[CTRL_READ];
                next_r.cnt = (wdata[CTRL_CNT_LSB +: 3] >= 3'(MAX_BYTES)) ?
                    3'(MAX_BYTES - 1) : wdata[CTRL_CNT_LSB +: 3];
                next_r.role = B_ADDRW;
                next_r.q = 2'h0;
                next_r.st = H_START;
            end else if (addr == H_TARGET_OFF) begin
                next_r.target = wdata[6:0];
            end else if (addr == H_SUB_OFF) begin
                next_r.sub = wdata;
            end else if (addr == H_STATUS_OFF && wdata[STAT_NACK]) begin
                next_r.nack = 1'b0;
            end else if (addr >= H_DATA_OFF && addr < H_DATA_OFF + 4'(MAX_BYTES)) begin
                next_r.data[addr - H_DATA_OFF] = wdata;
            end
        end
        if (rd) begin
            case (addr)
                H_CTRL_OFF:   next_r.rdata = {3'h0, r.cnt, r.rw, 1'b0};
                H_TARGET_OFF: next_r.rdata = {1'b0, r.target};
                H_SUB_OFF:    next_r.rdata = r.sub;
                H_STATUS_OFF: next_r.rdata = {6'h00, r.nack, r.st != H_IDLE};
                default: begin
                    next_r.rdata = 8'h00;
                    if (addr >= H_DATA_OFF && addr < H_DATA_OFF + 4'(MAX_BYTES)) begin
                        next_r.rdata = r.data[addr - H_DATA_OFF];
                    end
                end
            endcase
        end
        if (tick) begin
            next_r.q = r.q + 2'h1;
            case (r.st)
                H_START: begin
                    case (r.q)
                        2'h0: next_r.sda_oe = 1'b0;
                        2'h1: next_r.scl_oe = 1'b0;
                        2'h2: next_r.sda_oe = 1'b1;
                        default: begin
                            next_r.scl_oe = 1'b1;
                            next_r.tx = load;
                            next_r.bitn = 4'h0;
                            next_r.st = H_BIT;
                        end
                    endcase
                end
                H_BIT: begin
                    case (r.q)
                        2'h0: begin
                            if (r.bitn == 4'h8) begin
                                // Last byte of a read gets no ack
                                next_r.sda_oe = r.role == B_RDATA && !last;
                            end else begin
                                next_r.sda_oe = r.role != B_RDATA && !cur[7];
                                next_r.tx = {cur[6:0], 1'b0};
                            end
                        end
                        2'h1: next_r.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.bitn != 4'h8) begin
                                next_r.rx = {r.rx[6:0], r.sda_s};
                            end
                        end
                        default: begin
                            next_r.scl_oe = 1'b1;
                            next_r.bitn = r.bitn + 4'h1;
                            if (r.bitn == 4'h8) begin
                                next_r.bitn = 4'h0;
                                next_r.tx = load;
                                if (r.role != B_RDATA && r.sda_s) begin
                                    next_r.nack = 1'b1; // Set wins over clear
                                    next_r.st = H_STOP;
                                end else begin
                                    case (r.role)
                                        B_ADDRW: next_r.role = B_SUB;
                                        B_SUB: begin
                                            next_r.idx = 3'h0;
                                            next_r.role = r.rw ? B_ADDRR : B_WDATA;
                                            if (r.rw) begin
                                                next_r.st = H_START;
                                            end
                                        end
                                        B_ADDRR: begin
                                            next_r.idx = 3'h0;
                                            next_r.role = B_RDATA;
                                        end
                                        default: begin
                                            if (r.role == B_RDATA) begin
                                                next_r.data[r.idx] = r.rx;
                                            end
                                            next_r.idx = r.idx + 3'h1;
                                            if (last) begin
                                                next_r.st = H_STOP;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    case (r.q)
                        2'h0: next_r.sda_oe = 1'b1;
                        2'h1: next_r.scl_oe = 1'b0;
                        2'h2: next_r.sda_oe = 1'b0;
                        default: next_r.st = H_IDLE;
                    endcase
                end
                default: next_r.q = 2'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.scl_host_o  = 1'b0;
    assign link.scl_host_oe = r.scl_oe;
    assign link.sda_host_o  = 1'b0;
    assign link.sda_host_oe = r.sda_oe;
    assign rdata            = r.rdata;
endmodule : vdi_host

// ### tb/vdi_link_properties.sv
// Checker for the two-wire link between controller and decoder port.
// Assumes plain copies of the link signals and the shared system clock.
`timescale 1ns/100ps
module vdi_link_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_host_o,
    input wire logic scl_host_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_dev_pulls_low: assert property (
        sda_dev_oe |-> !sda_dev_o) else $error("device drives data high");
    a_host_data_low: assert property (
        sda_host_oe |-> !sda_host_o) else $error("host drives data high");
    a_host_clock_low: assert property (
        scl_host_oe |-> !scl_host_o) else $error("host drives clock high");
    // Synchroniser delay means a drive starts well inside the low phase
    a_drive_after_fall: assert property (
        $rose(sda_dev_oe) |-> !scl && !$past(scl, 2))
        else $error("device drive starts too soon");
    a_release_clock_low: assert property (
        $fell(sda_dev_oe) |-> !scl) else $error("release while clock high");
    a_ack_holds_high: assert property (
        $rose(scl) && sda_dev_oe |-> sda_dev_oe [*4])
        else $error("drive dropped in clock high");
    a_start_no_drive: assert property (
        scl && $past(scl) && $fell(sda) |-> !sda_dev_oe [*8])
        else $error("device drives after start");
    a_stop_no_drive: assert property (
        scl && $past(scl) && $rose(sda) |-> !sda_dev_oe [*8])
        else $error("device drives after stop");
endmodule : vdi_link_properties

// ### tb/tb.sv
// Bench joining the controller and the decoder port over the link.
// Assumes one 100 MHz clock; the controller divides the link clock.
`timescale 1ns/100ps
module tb;
    import vdi_pkg::*;
    logic       clk, resetn, wr, rd, strap, busy, wr_pulse;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, second_addr, wr_sub, wr_data;
    logic [7:0] last_sub, last_data;
    logic [1:0] sel, wr_map, last_map;
    int         n_wr = 0;
    int         n_errors = 0;
    int         num_checks = 0;
    vdi_link_if lnk ();
    // Quarter of 4 clocks gives the 160 ns link period
    vdi_host #(.QUARTER(4)) vdi_host_inst (.clk(clk), .resetn(resetn),
        .link(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    vdi_device vdi_device_inst (.clk(clk), .resetn(resetn), .link(lnk),
        .address_select_strap(strap), .sub_map_select(sel),
        .second_map_bus_address(second_addr), .busy(busy),
        .wr_pulse(wr_pulse), .wr_map(wr_map), .wr_sub(wr_sub),
        .wr_data(wr_data));
    vdi_link_properties vdi_link_properties_inst (.clk(clk),
        .resetn(resetn), .scl_host_o(lnk.scl_host_o),
        .scl_host_oe(lnk.scl_host_oe), .sda_host_o(lnk.sda_host_o),
        .sda_host_oe(lnk.sda_host_oe), .sda_dev_o(lnk.sda_dev_o),
        .sda_dev_oe(lnk.sda_dev_oe), .scl(lnk.scl), .sda(lnk.sda));
    always @(posedge clk) begin
        if (wr_pulse === 1'b1) begin
            n_wr      <= n_wr + 1;
            last_map  <= wr_map;
            last_sub  <= wr_sub;
            last_data <= wr_data;
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic rs(input logic [3:0] i, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(H_DATA_OFF + i, d);
        chk("slot", e, d);
    endtask : rs
    // One transfer; judges the nack flag and the count of committed writes
    task automatic xf(input logic [6:0] t, input logic [7:0] s,
        input logic rw, input logic [2:0] n, input logic en, input int dw);
        logic [7:0] st;
        int         w0;
        w0 = n_wr;
        wr_reg(H_TARGET_OFF, {1'b0, t});
        wr_reg(H_SUB_OFF, s);
        wr_reg(H_STATUS_OFF, 8'h02);
        wr_reg(H_CTRL_OFF, {3'h0, n - 3'h1, rw, 1'b1});
        st = 8'h01;
        for (int i = 0; i < 4000 && st[STAT_BUSY] !== 1'b0; i++)
            rd_reg(H_STATUS_OFF, st);
        chk("busy", 8'h00, {7'h0, st[STAT_BUSY]});
        if (st[STAT_BUSY] !== 1'b0) summarize();
        chk("nack", {7'h0, en}, {7'h0, st[STAT_NACK]});
        chk("writes", 8'(dw), 8'(n_wr - w0));
        chk("dev_busy", 8'h00, {7'h0, busy});
    endtask : xf
    task automatic t_seq;
        wr_reg(H_DATA_OFF, 8'ha5);
        wr_reg(H_DATA_OFF + 4'h1, 8'h5a);
        xf(7'h20, 8'h10, 1'b0, 3'h2, 1'b0, 2);
        chk("sub", 8'h11, last_sub);
        chk("data", 8'h5a, last_data);
        wr_reg(H_DATA_OFF, 8'h3c);
        xf(7'h20, 8'h10, 1'b0, 3'h1, 1'b0, 1);
        xf(7'h20, 8'h10, 1'b1, 3'h2, 1'b0, 0);
        rs(4'h0, 8'h3c);
        rs(4'h1, 8'h5a);
    endtask : t_seq
    task automatic t_addr;
        @(posedge clk) strap <= 1'b1;
        xf(7'h20, 8'h30, 1'b0, 3'h1, 1'b1, 0);
        xf(7'h21, 8'h30, 1'b0, 3'h1, 1'b0, 1);
        xf(7'h21, 8'hff, 1'b0, 3'h1, 1'b1, 0);
    endtask : t_addr
    task automatic t_sel;
        // Last pass writes code 00 back, as the master must
        for (int c = 0; c < 4; c++) begin
            wr_reg(H_DATA_OFF, 8'(c % 3) << SUBMAP_LSB);
            xf(7'h21, SUBMAP_SEL_OFF, 1'b0, 3'h1, 1'b0, 1);
            chk("select", 8'(c % 3), {6'h0, sel});
            wr_reg(H_DATA_OFF, 8'(c));
            xf(7'h21, 8'h20, 1'b0, 3'h1, 1'b0, 1);
            chk("map", 8'(c % 3), {6'h0, last_map});
        end
    endtask : t_sel
    task automatic t_top;
        xf(7'h44, 8'h05, 1'b0, 3'h1, 1'b1, 0);
        wr_reg(H_DATA_OFF, 8'h3c);
        wr_reg(H_DATA_OFF + 4'h1, 8'h88);
        wr_reg(H_DATA_OFF + 4'h2, 8'h77);
        xf(7'h21, 8'hfd, 1'b0, 3'h3, 1'b1, 2);
        chk("second", 8'h88, second_addr);
        xf(7'h21, 8'hfd, 1'b1, 3'h3, 1'b0, 0);
        rs(4'h0, 8'h3c);
        rs(4'h1, 8'h88);
        rs(4'h2, 8'h88);
        @(posedge clk) strap <= 1'b0;
        wr_reg(H_DATA_OFF, 8'h40);
        xf(7'h20, SUBMAP_SEL_OFF, 1'b0, 3'h1, 1'b0, 1);
        wr_reg(H_DATA_OFF, 8'h66);
        xf(7'h44, 8'h05, 1'b0, 3'h1, 1'b0, 1);
        chk("map", {6'h0, MAP_SECOND}, {6'h0, last_map});
        xf(7'h44, 8'h05, 1'b1, 3'h1, 1'b0, 0);
        rs(4'h0, 8'h66);
    endtask : t_top
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        logic [7:0] d;
        resetn = 1'b0;
        wr     = 1'b0;
        rd     = 1'b0;
        strap  = 1'b0;
        addr   = 4'h0;
        wdata  = 8'h00;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(H_STATUS_OFF, d);
        chk("status", 8'h00, d);
        chk("select", 8'h00, {6'h0, sel});
        chk("second", 8'h00, second_addr);
        t_seq();
        t_addr();
        t_sel();
        t_top();
        summarize();
    end
endmodule : tb
